// ==== rtl/freq_limit_jump_dc_brake_defs.svh ====
// constants for the frequency limit, jump band and dc braking block
// assumes frequencies in 0.01 Hz, percents in 1 %, block time in 10 ms ticks
// and brake times in 0.1 s; included by the braking top module only
`ifndef FREQ_LIMIT_JUMP_DC_BRAKE_DEFS_SVH
`define FREQ_LIMIT_JUMP_DC_BRAKE_DEFS_SVH

// clock and tick
`define CLK_HZ 40000000
`define TICK_MS 10
`define TIME_SCALE 13'h000A

// register word indices, byte address is four times the index
`define OFS_CTRL 4'h0
`define OFS_MAXF 4'h1
`define OFS_STARTF 4'h2
`define OFS_LIMITS 4'h3
`define OFS_JUMP1 4'h4
`define OFS_JUMP2 4'h5
`define OFS_JUMP3 4'h6
`define OFS_SETF 4'h7
`define OFS_PREBLK 4'h8
`define OFS_STOPBRK 4'h9
`define OFS_BRKF 4'hA
`define OFS_STARTBRK 4'hB
`define OFS_MOTOR 4'hC
`define OFS_RAMP 4'hD
`define OFS_STATUS 4'hE

// control register fields
`define CTRL_LIMIT_BIT 0
`define CTRL_JUMP_BIT 1
`define CTRL_STOP_LSB 2
`define CTRL_INERTIA_LSB 4
`define CTRL_INPUT3_LSB 6

// reset values and ranges
`define MAXF_RST 16'h1770
`define MAXF_MIN 16'h0FA0
`define MAXF_MAX 16'h9C40
`define STARTF_RST 16'h0032
`define STARTF_MIN 16'h000A
`define STARTF_MAX 16'h03E8
`define LOWER_RST 16'h0032
`define UPPER_RST 16'h1770
`define JUMP1_LOW_RST 16'h03E8
`define JUMP1_HIGH_RST 16'h05DC
`define JUMP2_LOW_RST 16'h07D0
`define JUMP2_HIGH_RST 16'h09C4
`define JUMP3_LOW_RST 16'h0BB8
`define JUMP3_HIGH_RST 16'h0DAC
`define SETF_RST 16'h0000
`define PREBLK_RST 13'h0000
`define PREBLK_MAX 13'h1770
`define STOPT_RST 10'h00A
`define STARTT_RST 10'h000
`define BRAKE_TIME_MAX 10'h258
`define STOPA_RST 8'h32
`define STARTA_RST 8'h32
`define PCT_MAX 8'hC8
`define BRKF_RST 16'h01F4
`define BRKF_MAX 16'h1770
`define RATED_RST 16'h0064
`define RAMP_RST 16'h000A
`define INPUT3_RST 5'h02
`define INPUT3_DC_STOP 5'h0B
`define GAIN_LOW 8'h10
`define GAIN_MID 8'h20
`define GAIN_HIGH 8'h40

`endif

// ==== rtl/freq_limit_jump_dc_brake_pkg.sv ====
// types shared by the conditioner, its interface and the braking top
// assumes the constants header sits beside it
package freq_limit_jump_dc_brake_pkg;

  typedef logic [15:0] freq_t;

  typedef enum logic [2:0] {
    ST_STOPPED = 3'b000,
    ST_HOLD_DC = 3'b001,
    ST_START_DC = 3'b010,
    ST_RUN = 3'b011,
    ST_DECEL = 3'b100,
    ST_BLOCK = 3'b101,
    ST_STOP_DC = 3'b110
  } brake_state_e;

  typedef enum logic [1:0] {
    STOP_DECEL = 2'b00,
    STOP_DC = 2'b01,
    STOP_COAST = 2'b10
  } stop_method_e;

  typedef struct packed {
    freq_t prev_set;
    logic falling;
    freq_t cond_freq;
  } cond_state_s;

  typedef struct packed {
    logic wait_req;
    logic [31:0] readdata;
    logic limit_enable;
    logic jump_enable;
    logic [1:0] stop_method;
    logic [1:0] load_inertia_class;
    logic [4:0] input3_function;
    freq_t max_frequency;
    freq_t start_frequency;
    freq_t lower_freq_limit;
    freq_t upper_freq_limit;
    freq_t [2:0] jump_low;
    freq_t [2:0] jump_high;
    freq_t set_freq;
    logic [12:0] pre_brake_block_time;
    logic [9:0] stop_brake_time;
    logic [7:0] stop_brake_amount;
    freq_t brake_start_freq;
    logic [9:0] start_brake_time;
    logic [7:0] start_brake_amount;
    freq_t rated_motor_current;
    freq_t ramp_step;
    logic [1:0] run_sync;
    logic [1:0] mi3_sync;
    logic [18:0] tick_cnt;
    logic tick;
    brake_state_e state;
    logic [12:0] phase_cnt;
    freq_t out_freq;
    logic out_enable;
    logic dc_inject;
    logic [15:0] dc_level;
    logic [7:0] brake_gain;
  } top_state_s;

endpackage : freq_limit_jump_dc_brake_pkg

// ==== rtl/freq_cond_if.sv ====
// carries settings into the frequency conditioner and its result back
// assumes both ends share the top's clock and synchronous reset
`timescale 1ns/1ps
`default_nettype none
interface freq_cond_if;
  import freq_limit_jump_dc_brake_pkg::*;
  logic clk;
  logic rst;
  freq_t set_freq;
  freq_t max_frequency;
  freq_t start_frequency;
  logic limit_enable;
  freq_t lower_freq_limit;
  freq_t upper_freq_limit;
  logic jump_enable;
  freq_t [2:0] jump_low;
  freq_t [2:0] jump_high;
  freq_t cond_freq;

  modport cond (
    input clk, rst, set_freq, max_frequency, start_frequency, limit_enable,
    input lower_freq_limit, upper_freq_limit, jump_enable, jump_low, jump_high,
    output cond_freq
  );
  modport user (
    output clk, rst, set_freq, max_frequency, start_frequency, limit_enable,
    output lower_freq_limit, upper_freq_limit, jump_enable, jump_low, jump_high,
    input cond_freq
  );
endinterface : freq_cond_if
`default_nettype wire

// ==== rtl/freq_conditioner.sv ====
// conditions the commanded frequency: max clamp, user limits, jump bands
// with direction hysteresis, then start-frequency zeroing
// assumes settings are already range-checked by the register file
`timescale 1ns/1ps
`default_nettype none
module freq_conditioner
  import freq_limit_jump_dc_brake_pkg::*;
(
  freq_cond_if.cond cif
);

  cond_state_s state_reg;
  cond_state_s state_next;
  logic [2:0] in_band;
  freq_t f_max;
  freq_t f_lim;
  freq_t f_jump;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_band
      assign in_band[gi] = cif.jump_enable && (f_lim >= cif.jump_low[gi]) &&
                           (f_lim <= cif.jump_high[gi]); // [RULE4]
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    f_max = (cif.set_freq > cif.max_frequency) ? cif.max_frequency : cif.set_freq; // [RULE1] [RULE20]
    f_lim = f_max;
    if (cif.limit_enable) begin
      if (f_lim > cif.upper_freq_limit) f_lim = cif.upper_freq_limit; // [RULE3]
      if (f_lim < cif.lower_freq_limit) f_lim = cif.lower_freq_limit; // [RULE3]
    end
    // an unchanged setting keeps the last direction so a held band edge stays put
    if (f_lim > state_reg.prev_set) state_next.falling = 1'b0;
    else if (f_lim < state_reg.prev_set) state_next.falling = 1'b1;
    state_next.prev_set = f_lim;
    f_jump = f_lim;
    for (int i = 2; i >= 0; i--) begin
      if (in_band[i]) begin
        f_jump = state_next.falling ? cif.jump_high[i] : cif.jump_low[i]; // [RULE6] [RULE7]
      end
    end
    state_next.cond_freq = (f_jump < cif.start_frequency) ? 16'h0000 : f_jump; // [RULE2] [RULE20]
  end

  always_ff @(posedge cif.clk) begin
    if (cif.rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cif.cond_freq = state_reg.cond_freq;

endmodule : freq_conditioner
`default_nettype wire

// ==== rtl/freq_limit_jump_dc_brake.sv ====
// frequency limit, jump band and dc braking controller with an avalon slave
// assumes run and input 3 pins are asynchronous; avalon on I_CLOCK
//
// How it works
// [RULE1] every frequency setting except base frequency is kept at or below max frequency
// [RULE2] a conditioned frequency below the start frequency becomes zero
// [RULE3] limit option one holds the set frequency between the user lower and upper limits
// [RULE4] jump option one keeps the command frequency out of three bands
// [RULE5] band bounds are accepted only between start and max, low not above high
// [RULE6] rising into a band holds the low bound until the setting passes above
// [RULE7] falling into a band holds the high bound until the setting drops below
// [RULE8] stop method one decelerates, then injects dc from the braking frequency
// [RULE9] output is blocked for the pre-brake block time before stop dc injection
// [RULE10] stop dc injection lasts the stop braking duration, up to 60 s
// [RULE11] stop dc level is a percentage, 0 to 200, of rated motor current
// [RULE12] stop dc injection starts at the braking frequency, start frequency to 60 Hz
// [RULE13] zero stop braking amount or duration skips stop dc injection
// [RULE14] load inertia class 0, 1, 2 selects the dc braking controller gain
// [RULE15] on start, dc at the start amount for start time, then accelerate
// [RULE16] zero start amount or time skips start dc and accelerates at once
// [RULE17] input 3 with function 11 requests dc braking while stopped at start amount
// [RULE18] stop method zero ramps down to zero, then stops running
// [RULE19] stop method two switches the output off at once, motor coasts
// [RULE20] conditioning order: max clamp, user limits, jump bands, start zeroing
// [RULE21] sequence decel, block, dc, stopped; a run command aborts the rest
`timescale 1ns/1ps
`default_nettype none
`include "freq_limit_jump_dc_brake_defs.svh"
module freq_limit_jump_dc_brake
  import freq_limit_jump_dc_brake_pkg::*;
#(
  parameter int TICK_CYCLES = `CLK_HZ / 1000 * `TICK_MS
) (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic I_RUN,
  input wire logic I_MULTI_INPUT_3,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  output logic [15:0] O_OUT_FREQ,
  output logic O_OUT_ENABLE,
  output logic O_DC_INJECT,
  output logic [15:0] O_DC_LEVEL,
  output logic [7:0] O_BRAKE_GAIN
);

  top_state_s state_reg;
  top_state_s state_next;
  freq_cond_if cif ();

  freq_conditioner u_cond (
    .cif(cif)
  );

  assign cif.clk = I_CLOCK;
  assign cif.rst = I_RST;
  assign cif.set_freq = state_reg.set_freq;
  assign cif.max_frequency = state_reg.max_frequency;
  assign cif.start_frequency = state_reg.start_frequency;
  assign cif.limit_enable = state_reg.limit_enable;
  assign cif.lower_freq_limit = state_reg.lower_freq_limit;
  assign cif.upper_freq_limit = state_reg.upper_freq_limit;
  assign cif.jump_enable = state_reg.jump_enable;
  assign cif.jump_low = state_reg.jump_low;
  assign cif.jump_high = state_reg.jump_high;

  function automatic freq_t clamp_f(input freq_t v, input freq_t lo, input freq_t hi);
    clamp_f = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp_f

  function automatic freq_t ramp_to(input freq_t cur, input freq_t tgt, input freq_t step);
    if (cur < tgt) ramp_to = ((tgt - cur) > step) ? freq_t'(cur + step) : tgt;
    else ramp_to = ((cur - tgt) > step) ? freq_t'(cur - step) : tgt;
  endfunction : ramp_to

  logic run_cmd;
  logic mi3_cmd;
  logic start_dc_skip;
  logic stop_dc_skip;
  logic [12:0] phase_target;
  logic [23:0] dc_product;
  logic [7:0] dc_amount;
  freq_t wr_lo;
  freq_t wr_hi;
  logic [31:0] rd_mux;

  always_comb begin
    state_next = state_reg;
    run_cmd = state_reg.run_sync[1];
    mi3_cmd = state_reg.mi3_sync[1] && (state_reg.input3_function == `INPUT3_DC_STOP); // [RULE17]
    start_dc_skip = (state_reg.start_brake_amount == 8'h00) ||
                    (state_reg.start_brake_time == 10'h000); // [RULE16]
    stop_dc_skip = (state_reg.stop_brake_amount == 8'h00) ||
                   (state_reg.stop_brake_time == 10'h000); // [RULE13]
    wr_lo = I_AVS_WRITEDATA[15:0];
    wr_hi = I_AVS_WRITEDATA[31:16];
    dc_amount = 8'h00;
    phase_target = 13'h0000;

    // pins pass two flops before anything reads them
    state_next.run_sync = {state_reg.run_sync[0], I_RUN};
    state_next.mi3_sync = {state_reg.mi3_sync[0], I_MULTI_INPUT_3};

    // 10 ms tick from the main clock
    state_next.tick = 1'b0;
    if (state_reg.tick_cnt == 19'(TICK_CYCLES - 1)) begin
      state_next.tick_cnt = 19'h00000;
      state_next.tick = 1'b1;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + 19'h00001;
    end

    // avalon slave: one wait cycle, then the answer; writes land on the answer edge
    case (I_AVS_ADDRESS)
      `OFS_CTRL: rd_mux = {21'h000000, state_reg.input3_function,
                           state_reg.load_inertia_class, state_reg.stop_method,
                           state_reg.jump_enable, state_reg.limit_enable};
      `OFS_MAXF: rd_mux = {16'h0000, state_reg.max_frequency};
      `OFS_STARTF: rd_mux = {16'h0000, state_reg.start_frequency};
      `OFS_LIMITS: rd_mux = {state_reg.upper_freq_limit, state_reg.lower_freq_limit};
      `OFS_JUMP1: rd_mux = {state_reg.jump_high[0], state_reg.jump_low[0]};
      `OFS_JUMP2: rd_mux = {state_reg.jump_high[1], state_reg.jump_low[1]};
      `OFS_JUMP3: rd_mux = {state_reg.jump_high[2], state_reg.jump_low[2]};
      `OFS_SETF: rd_mux = {16'h0000, state_reg.set_freq};
      `OFS_PREBLK: rd_mux = {19'h00000, state_reg.pre_brake_block_time};
      `OFS_STOPBRK: rd_mux = {8'h00, state_reg.stop_brake_amount, 6'h00,
                              state_reg.stop_brake_time};
      `OFS_BRKF: rd_mux = {16'h0000, state_reg.brake_start_freq};
      `OFS_STARTBRK: rd_mux = {8'h00, state_reg.start_brake_amount, 6'h00,
                               state_reg.start_brake_time};
      `OFS_MOTOR: rd_mux = {16'h0000, state_reg.rated_motor_current};
      `OFS_RAMP: rd_mux = {16'h0000, state_reg.ramp_step};
      `OFS_STATUS: rd_mux = {8'h00, 2'h0, state_reg.dc_inject, state_reg.out_enable,
                             1'b0, state_reg.state, state_reg.out_freq};
      default: rd_mux = 32'h00000000;
    endcase
    state_next.wait_req = 1'b1;
    if ((I_AVS_READ || I_AVS_WRITE) && state_reg.wait_req) begin
      state_next.wait_req = 1'b0;
      state_next.readdata = I_AVS_READ ? rd_mux : 32'h00000000;
    end
    if (I_AVS_WRITE && !state_reg.wait_req) begin
      case (I_AVS_ADDRESS)
        `OFS_CTRL: begin
          state_next.limit_enable = I_AVS_WRITEDATA[`CTRL_LIMIT_BIT];
          state_next.jump_enable = I_AVS_WRITEDATA[`CTRL_JUMP_BIT];
          state_next.stop_method = I_AVS_WRITEDATA[`CTRL_STOP_LSB +: 2];
          state_next.load_inertia_class = I_AVS_WRITEDATA[`CTRL_INERTIA_LSB +: 2];
          state_next.input3_function = I_AVS_WRITEDATA[`CTRL_INPUT3_LSB +: 5];
        end
        `OFS_MAXF: state_next.max_frequency = clamp_f(wr_lo, `MAXF_MIN, `MAXF_MAX);
        `OFS_STARTF: state_next.start_frequency = clamp_f(wr_lo, `STARTF_MIN,
                                                          `STARTF_MAX);
        `OFS_LIMITS: begin
          state_next.upper_freq_limit = clamp_f(wr_hi, 16'h0000,
                                                state_reg.max_frequency); // [RULE1]
          state_next.lower_freq_limit = clamp_f(wr_lo, state_reg.start_frequency,
                                                state_next.upper_freq_limit);
        end
        `OFS_JUMP1, `OFS_JUMP2, `OFS_JUMP3: begin
          // a band outside start..max or turned round is refused whole
          if ((wr_lo >= state_reg.start_frequency) && (wr_lo <= wr_hi) &&
              (wr_hi <= state_reg.max_frequency)) begin // [RULE5]
            state_next.jump_low[I_AVS_ADDRESS[1:0] - 2'h0] = wr_lo;
            state_next.jump_high[I_AVS_ADDRESS[1:0] - 2'h0] = wr_hi;
          end
        end
        `OFS_SETF: state_next.set_freq = clamp_f(wr_lo, 16'h0000,
                                                 state_reg.max_frequency); // [RULE1]
        `OFS_PREBLK: state_next.pre_brake_block_time =
            (I_AVS_WRITEDATA[12:0] > `PREBLK_MAX) ? `PREBLK_MAX : I_AVS_WRITEDATA[12:0];
        `OFS_STOPBRK: begin
          state_next.stop_brake_time = (I_AVS_WRITEDATA[9:0] > `BRAKE_TIME_MAX) ?
                                       `BRAKE_TIME_MAX : I_AVS_WRITEDATA[9:0]; // [RULE10]
          state_next.stop_brake_amount = (I_AVS_WRITEDATA[23:16] > `PCT_MAX) ?
                                         `PCT_MAX : I_AVS_WRITEDATA[23:16]; // [RULE11]
        end
        `OFS_BRKF: state_next.brake_start_freq = clamp_f(wr_lo, state_reg.start_frequency,
            (state_reg.max_frequency < `BRKF_MAX) ? state_reg.max_frequency
                                                  : `BRKF_MAX); // [RULE12]
        `OFS_STARTBRK: begin
          state_next.start_brake_time = (I_AVS_WRITEDATA[9:0] > `BRAKE_TIME_MAX) ?
                                        `BRAKE_TIME_MAX : I_AVS_WRITEDATA[9:0];
          state_next.start_brake_amount = (I_AVS_WRITEDATA[23:16] > `PCT_MAX) ?
                                          `PCT_MAX : I_AVS_WRITEDATA[23:16];
        end
        `OFS_MOTOR: state_next.rated_motor_current = wr_lo;
        `OFS_RAMP: state_next.ramp_step = wr_lo;
        default: state_next.readdata = state_reg.readdata;
      endcase
    end

    // braking sequencer, counting 10 ms ticks in phase_cnt
    case (state_reg.state)
      ST_START_DC: phase_target = 13'(state_reg.start_brake_time * `TIME_SCALE);
      ST_BLOCK: phase_target = state_reg.pre_brake_block_time;
      ST_STOP_DC: phase_target = 13'(state_reg.stop_brake_time * `TIME_SCALE);
      default: phase_target = 13'h0000;
    endcase
    if (state_reg.tick) state_next.phase_cnt = state_reg.phase_cnt + 13'h0001;

    case (state_reg.state)
      ST_STOPPED: begin
        state_next.out_freq = 16'h0000;
        state_next.phase_cnt = 13'h0000;
        if (run_cmd) begin
          state_next.state = start_dc_skip ? ST_RUN : ST_START_DC; // [RULE15] [RULE16]
        end else if (mi3_cmd) begin
          state_next.state = ST_HOLD_DC; // [RULE17]
        end
      end
      ST_HOLD_DC: begin
        if (run_cmd || !mi3_cmd) state_next.state = ST_STOPPED;
      end
      ST_START_DC: begin
        if (!run_cmd) begin
          state_next.state = ST_STOPPED;
        end else if (state_reg.phase_cnt >= phase_target) begin
          state_next.state = ST_RUN; // [RULE15]
        end
      end
      ST_RUN: begin
        if (state_reg.tick) begin
          state_next.out_freq = ramp_to(state_reg.out_freq, cif.cond_freq,
                                        state_reg.ramp_step);
        end
        if (!run_cmd) begin
          if (state_reg.stop_method == STOP_COAST) begin
            state_next.state = ST_STOPPED; // [RULE19]
            state_next.out_freq = 16'h0000;
          end else begin
            state_next.state = ST_DECEL;
          end
        end
      end
      ST_DECEL: begin
        if (state_reg.tick) begin
          state_next.out_freq = ramp_to(state_reg.out_freq, 16'h0000,
                                        state_reg.ramp_step); // [RULE18]
        end
        if (run_cmd) begin
          state_next.state = ST_RUN; // [RULE21]
        end else if ((state_reg.stop_method == STOP_DC) && !stop_dc_skip &&
                     (state_reg.out_freq <= state_reg.brake_start_freq)) begin
          state_next.state = ST_BLOCK; // [RULE8] [RULE12] [RULE21]
          state_next.out_freq = 16'h0000;
          state_next.phase_cnt = 13'h0000;
        end else if (state_reg.out_freq == 16'h0000) begin
          state_next.state = ST_STOPPED; // [RULE18] [RULE13]
        end
      end
      ST_BLOCK: begin
        if (run_cmd) begin
          state_next.state = ST_RUN; // [RULE21]
        end else if (state_reg.phase_cnt >= phase_target) begin
          state_next.state = ST_STOP_DC; // [RULE9]
          state_next.phase_cnt = 13'h0000;
        end
      end
      ST_STOP_DC: begin
        if (run_cmd) begin
          state_next.state = ST_RUN; // [RULE21]
        end else if (state_reg.phase_cnt >= phase_target) begin
          state_next.state = ST_STOPPED; // [RULE10]
        end
      end
      default: state_next.state = ST_STOPPED;
    endcase

    // outputs follow the state being entered, so they change with it
    case (state_next.state)
      ST_HOLD_DC, ST_START_DC: dc_amount = state_reg.start_brake_amount; // [RULE15] [RULE17]
      ST_STOP_DC: dc_amount = state_reg.stop_brake_amount; // [RULE11]
      default: dc_amount = 8'h00;
    endcase
    state_next.dc_inject = (state_next.state == ST_HOLD_DC) ||
                           (state_next.state == ST_START_DC) ||
                           (state_next.state == ST_STOP_DC);
    state_next.out_enable = (state_next.state != ST_STOPPED) &&
                            (state_next.state != ST_BLOCK); // [RULE9] [RULE19]
    dc_product = 24'(dc_amount) * 24'(state_reg.rated_motor_current);
    state_next.dc_level = 16'(dc_product / 24'h000064); // [RULE11]
    case (state_reg.load_inertia_class)
      2'h0: state_next.brake_gain = `GAIN_LOW; // [RULE14]
      2'h1: state_next.brake_gain = `GAIN_MID; // [RULE14]
      default: state_next.brake_gain = `GAIN_HIGH; // [RULE14]
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      state_reg <= '0;
      state_reg.wait_req <= 1'b1;
      state_reg.stop_method <= STOP_DECEL;
      state_reg.input3_function <= `INPUT3_RST;
      state_reg.max_frequency <= `MAXF_RST;
      state_reg.start_frequency <= `STARTF_RST;
      state_reg.lower_freq_limit <= `LOWER_RST;
      state_reg.upper_freq_limit <= `UPPER_RST;
      state_reg.jump_low <= {`JUMP3_LOW_RST, `JUMP2_LOW_RST, `JUMP1_LOW_RST};
      state_reg.jump_high <= {`JUMP3_HIGH_RST, `JUMP2_HIGH_RST, `JUMP1_HIGH_RST};
      state_reg.set_freq <= `SETF_RST;
      state_reg.pre_brake_block_time <= `PREBLK_RST;
      state_reg.stop_brake_time <= `STOPT_RST;
      state_reg.stop_brake_amount <= `STOPA_RST;
      state_reg.brake_start_freq <= `BRKF_RST;
      state_reg.start_brake_time <= `STARTT_RST;
      state_reg.start_brake_amount <= `STARTA_RST;
      state_reg.rated_motor_current <= `RATED_RST;
      state_reg.ramp_step <= `RAMP_RST;
      state_reg.state <= ST_STOPPED;
      state_reg.brake_gain <= `GAIN_LOW;
    end else begin
      state_reg <= state_next;
    end
  end

  assign O_AVS_READDATA = state_reg.readdata;
  assign O_AVS_WAITREQUEST = state_reg.wait_req;
  assign O_OUT_FREQ = state_reg.out_freq;
  assign O_OUT_ENABLE = state_reg.out_enable;
  assign O_DC_INJECT = state_reg.dc_inject;
  assign O_DC_LEVEL = state_reg.dc_level;
  assign O_BRAKE_GAIN = state_reg.brake_gain;

endmodule : freq_limit_jump_dc_brake
`default_nettype wire

// ==== tb/fljdb_sva.sv ====
// port assertions for the braking block
// assumes one clock and a synchronous reset
`timescale 1ns/1ps
`default_nettype none
module fljdb_sva (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic [15:0] O_OUT_FREQ,
  input wire logic O_OUT_ENABLE,
  input wire logic O_DC_INJECT,
  input wire logic [7:0] O_BRAKE_GAIN
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  sequence s_req;
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
  endsequence
  sequence s_nul_rd;
    I_AVS_READ && I_AVS_ADDRESS == 4'hF && O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST;
  endsequence
  a_wait_one: assert property (s_req |=> !O_AVS_WAITREQUEST)
    else $error("answer late");
  a_wait_pulse: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("answer too long");
  a_rdata_hold: assert property (O_AVS_WAITREQUEST && $past(O_AVS_WAITREQUEST)
    |-> $stable(O_AVS_READDATA)) else $error("read data moved");
  a_nul_zero: assert property (s_nul_rd |-> O_AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_rst_vals: assert property ($fell(I_RST) |-> O_AVS_WAITREQUEST && !O_DC_INJECT
    && !O_OUT_ENABLE && O_BRAKE_GAIN == 8'h10) else $error("bad reset state");
  a_freq_max: assert property (O_OUT_FREQ <= 16'h9C40)
    else $error("frequency above max");
  a_off_zero: assert property (!O_OUT_ENABLE |-> O_OUT_FREQ == 16'h0)
    else $error("frequency while off");
  a_gain_code: assert property (O_BRAKE_GAIN inside {8'h10, 8'h20, 8'h40})
    else $error("bad gain code");
endmodule : fljdb_sva
bind freq_limit_jump_dc_brake fljdb_sva u_sva (.I_CLOCK, .I_RST, .I_AVS_ADDRESS,
  .I_AVS_READ, .I_AVS_WRITE, .O_AVS_READDATA, .O_AVS_WAITREQUEST, .O_OUT_FREQ,
  .O_OUT_ENABLE, .O_DC_INJECT, .O_BRAKE_GAIN);
`default_nettype wire

// ==== tb/motor_model.sv ====
// motor behind the output stage, seen as speed only
// assumes the block's clock; dc injection holds it still
`timescale 1ns/1ps
`default_nettype none
module motor_model (
  input wire logic clk,
  input wire logic [15:0] i_freq,
  input wire logic i_on,
  input wire logic i_dc,
  output var logic [15:0] o_speed = 16'h0
);
  // coasting sheds one unit a cycle: crude, but never stops at once
  always @(posedge clk) begin
    if (i_dc) o_speed <= 16'h0;
    else if (i_on) o_speed <= i_freq;
    else if (o_speed != 16'h0) o_speed <= o_speed - 16'h1;
  end
endmodule : motor_model
`default_nettype wire

// ==== tb/freq_limit_jump_dc_brake_tb_top.sv ====
// bench: avalon accesses and pin drives with port comparisons
// assumes a 4-cycle tick so timed phases stay short
`timescale 1ns/1ps
`default_nettype none
module freq_limit_jump_dc_brake_tb_top;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, run = 1'b0, mi3 = 1'b0;
  logic [3:0] ad = 4'h0;
  logic [31:0] wd = 32'h0, rdq, rv;
  logic wq, en, dc;
  logic [15:0] f, lvl, spd;
  logic [7:0] gn;
  int err_count = 0, checked = 0, cyc = 0, n;
  initial forever #12.5 clk = ~clk;
  freq_limit_jump_dc_brake #(.TICK_CYCLES(4)) uut (.I_CLOCK(clk), .I_RST(rst),
    .I_AVS_ADDRESS(ad), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
    .I_RUN(run), .I_MULTI_INPUT_3(mi3), .O_AVS_READDATA(rdq), .O_AVS_WAITREQUEST(wq),
    .O_OUT_FREQ(f), .O_OUT_ENABLE(en), .O_DC_INJECT(dc), .O_DC_LEVEL(lvl), .O_BRAKE_GAIN(gn));
  motor_model motor (.clk(clk), .i_freq(f), .i_on(en), .i_dc(dc), .o_speed(spd));
  task stop_test;
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    do @(posedge clk); while (wq !== 1'b0);
    rv = rdq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc
  task rdc(input logic [3:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk("readdata", e, rv);
  endtask : rdc
  // the hold after the match catches a ramp that only passes through
  task wf(input logic [15:0] e);
    for (n = 0; n < 4000 && f !== e; n++) @(posedge clk);
    repeat (40) @(posedge clk);
    chk("out_freq", {16'h0, e}, {16'h0, f});
  endtask : wf
  task wdc(input logic v);
    for (n = 0; n < 4000 && dc !== v; n++) @(posedge clk);
  endtask : wdc
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(4'h1, 32'h1770);
    rdc(4'hF, 32'h0);
    acc(1'b1, 4'h7, 32'hFFFF);
    rdc(4'h7, 32'h1770);
    acc(1'b1, 4'h4, 32'h0300_0400);
    rdc(4'h4, 32'h05DC_03E8);
    acc(1'b1, 4'h7, 32'h0);
    acc(1'b1, 4'h0, 32'h2);
    acc(1'b1, 4'h7, 32'h04B0);
    run <= 1'b1;
    wf(16'h03E8);
    acc(1'b1, 4'h7, 32'h0640);
    wf(16'h0640);
    acc(1'b1, 4'h7, 32'h04B0);
    wf(16'h05DC);
    acc(1'b1, 4'h7, 32'h0014);
    wf(16'h0000);
    acc(1'b1, 4'h0, 32'h3);
    wf(16'h0032);
    acc(1'b1, 4'h0, 32'h16);
    acc(1'b1, 4'h7, 32'h0640);
    wf(16'h0640);
    chk("gain", 32'h20, gn);
    run <= 1'b0;
    wdc(1'b1);
    chk("dc_level", 32'h32, lvl);
    wdc(1'b0);
    chk("dc_span", 32'h1, n >= 396 && n <= 408);
    chk("speed", 32'h0, spd);
    acc(1'b1, 4'h9, 32'hA);
    run <= 1'b1;
    wf(16'h0640);
    run <= 1'b0;
    wdc(1'b1);
    chk("dc_inject", 32'h0, dc);
    acc(1'b1, 4'hB, 32'h0032_0001);
    run <= 1'b1;
    wdc(1'b1);
    wdc(1'b0);
    chk("start_span", 32'h1, n >= 36 && n <= 48);
    wf(16'h0640);
    acc(1'b1, 4'h0, 32'hA);
    run <= 1'b0;
    repeat (6) @(posedge clk);
    chk("out_enable", 32'h0, en);
    acc(1'b1, 4'h0, 32'h2C0);
    mi3 <= 1'b1;
    wdc(1'b1);
    chk("hold_level", 32'h32, lvl);
    acc(1'b1, 4'h8, 32'h14);
    acc(1'b1, 4'h9, 32'h0032_000A);
    acc(1'b1, 4'h0, 32'h4);
    run <= 1'b1;
    wf(16'h0640);
    run <= 1'b0;
    wdc(1'b1);
    chk("block_span", 32'h1, n >= 505 && n <= 540);
    run <= 1'b1;
    wdc(1'b0);
    chk("abort_span", 32'h1, n < 8);
    wf(16'h0640);
    stop_test;
  end
endmodule : freq_limit_jump_dc_brake_tb_top
`default_nettype wire
